// ---- pscfg_regs.sv ----
// Modbus configuration and identification register bank
`timescale 1ns/1ps

// Function
// - Input regs via read-input; reserved input 12-20 and holding 7 read 0.
// - Rate code 0..6 selects 4800 to 230400 baud; default code 2.
// - No traffic for timeout minutes zeroes outputs; 0 disables, default 0.
// - Termination resistor connected when setting is 1, default off.
// - Writing 1 to restore reloads defaults, then clears back to 0.
// - Low alert at most setpoint and at most range top minus 50 Pa.
// - High alert at least setpoint and at least range bottom plus 50 Pa.
// - Model identifier word is read-only.
// - Hardware revision word read-only, major high byte, minor low byte.
// - Firmware revision word read-only, same byte encoding.
// - Alert flag set when pressure outside thresholds, off during auto-tune.
module pscfg_regs #(
	parameter logic [15:0] MODEL_ID    = 16'h0a5a, // Value is arbitrary
	parameter logic [15:0] HW_REV      = 16'h0101, // Value is arbitrary
	parameter logic [15:0] FW_REV      = 16'h0102, // Value is arbitrary
	parameter logic [15:0] RANGE_MIN   = 16'h0000,
	parameter logic [15:0] RANGE_MAX   = 16'h03e8,
	parameter int unsigned MIN_CYCLES  = pscfg_pkg::CYC_PER_MIN
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Decoded request from the frame parser
	input  wire logic        req_valid,
	input  wire logic [7:0]  req_func,
	input  wire logic [15:0] req_addr,
	input  wire logic [15:0] req_wdata,
	// Answer, one cycle after the request
	output logic             resp_valid,
	output logic             resp_exc,
	output logic [7:0]       resp_exc_code,
	output logic [15:0]      resp_data,
	// Frame address filter
	input  wire logic        frame_seen,
	input  wire logic [7:0]  frame_addr,
	output logic             addr_match,
	// Link settings
	output logic             bit_tick,
	output pscfg_pkg::pscfg_parity_t parity_mode,
	output logic             term_en,
	// Process side
	input  wire logic [15:0] pressure,
	input  wire logic [15:0] setpoint,
	input  wire logic        autotune,
	output logic             alert,
	output logic             outputs_zero
);
	import pscfg_pkg::*;

	// ==========================================================
	// Storage
	logic [7:0]  slave_q;
	logic [2:0]  rate_q;
	logic [1:0]  parity_q;
	logic [5:0]  timeout_q;
	logic        term_q;
	logic        restore_q;
	logic [15:0] low_q;
	logic [15:0] high_q;
	logic [31:0] cyc_q;
	logic [5:0]  mins_q;
	logic [15:0] rd_d;
	logic [7:0]  exc_d;
	logic        wr_ok;

	// ==========================================================
	// Read data and write legality per register
	always_comb begin
		exc_d = 8'h00;
		rd_d  = 16'h0000;
		if (req_func == FN_RD_INP) begin
			if (req_addr >= IR_RSVD_LO && req_addr <= IR_RSVD_HI) begin
				rd_d = 16'h0000;
			end else begin
				exc_d = EX_ADDR;
			end
		end else if (req_func == FN_RD_HOLD) begin
			if (req_addr == HR_SLAVE) begin
				rd_d = {8'h00, slave_q};
			end else if (req_addr == HR_RATE) begin
				rd_d = {13'h0000, rate_q};
			end else if (req_addr == HR_PARITY) begin
				rd_d = {14'h0000, parity_q};
			end else if (req_addr == HR_MODEL) begin
				rd_d = MODEL_ID;
			end else if (req_addr == HR_HW_REV) begin
				rd_d = HW_REV;
			end else if (req_addr == HR_FW_REV) begin
				rd_d = FW_REV;
			end else if (req_addr == HR_RSVD) begin
				rd_d = 16'h0000;
			end else if (req_addr == HR_TIMEOUT) begin
				rd_d = {10'h000, timeout_q};
			end else if (req_addr == HR_TERM) begin
				rd_d = {15'h0000, term_q};
			end else if (req_addr == HR_RESTORE) begin
				rd_d = {15'h0000, restore_q};
			end else if (req_addr == HR_LOW_ALRT) begin
				rd_d = low_q;
			end else if (req_addr == HR_HIGH_ALRT) begin
				rd_d = high_q;
			end else begin
				exc_d = EX_ADDR;
			end
		end else if (req_func == FN_WR_ONE) begin
			rd_d = req_wdata;
			if (req_addr == HR_SLAVE) begin
				if (req_wdata < SLAVE_MIN || req_wdata > SLAVE_MAX)
					exc_d = EX_VALUE;
			end else if (req_addr == HR_RATE) begin
				if (req_wdata > RATE_MAX)
					exc_d = EX_VALUE;
			end else if (req_addr == HR_PARITY) begin
				if (req_wdata > PARITY_MAX)
					exc_d = EX_VALUE;
			end else if (req_addr == HR_TIMEOUT) begin
				if (req_wdata > TIMEOUT_MAX)
					exc_d = EX_VALUE;
			end else if (req_addr == HR_TERM ||
				req_addr == HR_RESTORE) begin
				if (req_wdata > FLAG_MAX)
					exc_d = EX_VALUE;
			end else if (req_addr == HR_LOW_ALRT) begin
				if (req_wdata > setpoint ||
					req_wdata > RANGE_MAX - ALERT_GAP)
					exc_d = EX_VALUE;
			end else if (req_addr == HR_HIGH_ALRT) begin
				if (req_wdata < setpoint ||
					req_wdata < RANGE_MIN + ALERT_GAP ||
					req_wdata > RANGE_MAX)
					exc_d = EX_VALUE;
			end else begin
				// Identity and reserved words refuse writes
				exc_d = EX_ADDR;
			end
		end else begin
			exc_d = EX_FUNC;
		end
	end

	assign wr_ok = req_valid && req_func == FN_WR_ONE && exc_d == 8'h00;

	// ==========================================================
	// Answer register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			resp_valid    <= 1'b0;
			resp_exc      <= 1'b0;
			resp_exc_code <= 8'h00;
			resp_data     <= 16'h0000;
		end else begin
			resp_valid    <= req_valid;
			resp_exc      <= req_valid && exc_d != 8'h00;
			resp_exc_code <= req_valid ? exc_d : 8'h00;
			resp_data     <= (req_valid && exc_d == 8'h00) ? rd_d : 16'h0000;
		end
	end

	// ==========================================================
	// Holding registers; restore wins over a write in the reload cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n || restore_q) begin
			slave_q   <= RST_SLAVE[7:0];
			rate_q    <= RST_RATE[2:0];
			parity_q  <= RST_PARITY[1:0];
			timeout_q <= RST_TIMEOUT[5:0];
			term_q    <= RST_TERM[0];
			low_q     <= RST_LOW;
			high_q    <= RANGE_MAX;
		end else if (wr_ok) begin
			if (req_addr == HR_SLAVE)
				slave_q <= req_wdata[7:0];
			if (req_addr == HR_RATE)
				rate_q <= req_wdata[2:0];
			if (req_addr == HR_PARITY)
				parity_q <= req_wdata[1:0];
			if (req_addr == HR_TIMEOUT)
				timeout_q <= req_wdata[5:0];
			if (req_addr == HR_TERM)
				term_q <= req_wdata[0];
			if (req_addr == HR_LOW_ALRT)
				low_q <= req_wdata;
			if (req_addr == HR_HIGH_ALRT)
				high_q <= req_wdata;
		end
	end

	// Command reads back 1 for the one cycle the reload takes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			restore_q <= RST_RESTORE[0];
		end else if (restore_q) begin
			restore_q <= 1'b0;
		end else if (wr_ok && req_addr == HR_RESTORE) begin
			restore_q <= req_wdata[0];
		end
	end

	// ==========================================================
	// Link settings and address filter
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			parity_mode <= PSCFG_PAR_EVEN;
			term_en     <= 1'b0;
			addr_match  <= 1'b0;
		end else begin
			parity_mode <= pscfg_parity_t'(parity_q);
			term_en     <= term_q;
			addr_match  <= frame_seen && frame_addr == slave_q;
		end
	end

	pscfg_bit_tick u_tick (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.rate_code (rate_q),
		.bit_tick  (bit_tick)
	);

	// ==========================================================
	// Silence timeout; any frame on the line restarts it
	always_ff @(posedge clk_sys) begin
		if (!rst_n || frame_seen || timeout_q == 6'h00) begin
			cyc_q        <= 32'h0000_0000;
			mins_q       <= 6'h00;
			outputs_zero <= 1'b0;
		end else if (!outputs_zero) begin
			if (cyc_q == 32'(MIN_CYCLES - 1)) begin
				cyc_q  <= 32'h0000_0000;
				mins_q <= mins_q + 6'h01;
				if (mins_q + 6'h01 >= timeout_q)
					outputs_zero <= 1'b1;
			end else begin
				cyc_q <= cyc_q + 32'h0000_0001;
			end
		end
	end

	// ==========================================================
	// Pressure alert; pressure is signed, thresholds are not
	always_ff @(posedge clk_sys) begin
		if (!rst_n || autotune) begin
			alert <= 1'b0;
		end else begin
			alert <= pressure[15] || pressure < low_q ||
				pressure > high_q;
		end
	end

	// ==========================================================
	// Checks
	resp_timing_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req_valid |=> resp_valid ##1 !resp_valid || $past(req_valid))
		else $error("answer not one cycle after request");

	rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req_valid && req_func == FN_RD_INP && req_addr >= IR_RSVD_LO &&
		req_addr <= IR_RSVD_HI |=> resp_data == 16'h0000 && !resp_exc)
		else $error("reserved input register not zero");

	rate_legal_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rate_q <= RATE_MAX[2:0])
		else $error("rate code out of range");

	slave_legal_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		slave_q >= SLAVE_MIN[7:0] && slave_q <= SLAVE_MAX[7:0])
		else $error("slave address out of range");

	timeout_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(outputs_zero) |-> $past(timeout_q) != 6'h00 &&
		$past(mins_q) + 6'h01 >= $past(timeout_q))
		else $error("outputs zeroed without expired timeout");

	term_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!restore_q && wr_ok && req_addr == HR_TERM |=> ##1
		term_en == $past(req_wdata[0], 2))
		else $error("termination does not follow setting");

	restore_seq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!restore_q && wr_ok && req_addr == HR_RESTORE && req_wdata[0]
		|=> restore_q
		##1 (!restore_q && slave_q == RST_SLAVE[7:0] &&
		rate_q == RST_RATE[2:0] && high_q == RANGE_MAX))
		else $error("restore did not reload and clear");

	low_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		low_q <= RANGE_MAX - ALERT_GAP)
		else $error("low alert above range top minus gap");

	high_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		high_q >= RANGE_MIN + ALERT_GAP)
		else $error("high alert below range bottom plus gap");

	id_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req_valid && req_func == FN_RD_HOLD && req_addr == HR_MODEL
		|=> resp_data == MODEL_ID && !resp_exc)
		else $error("model identifier misread");

	ro_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req_valid && req_func == FN_WR_ONE && (req_addr == HR_HW_REV ||
		req_addr == HR_FW_REV) |=> resp_exc && resp_exc_code == EX_ADDR)
		else $error("revision word accepted a write");

	alert_tune_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		autotune |=> !alert)
		else $error("alert raised during auto-tune");

	hw_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req_valid && req_func == FN_RD_HOLD && req_addr == HR_HW_REV
		|=> resp_data == HW_REV && !resp_exc)
		else $error("hardware revision misread");

	fw_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req_valid && req_func == FN_RD_HOLD && req_addr == HR_FW_REV
		|=> resp_data == FW_REV && !resp_exc)
		else $error("firmware revision misread");

	rsvd_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req_valid && req_func == FN_RD_HOLD && req_addr == HR_RSVD
		|=> resp_data == 16'h0000 && !resp_exc)
		else $error("reserved holding word not zero");

	parity_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> parity_mode == $past(parity_q))
		else $error("parity mode does not follow setting");

	addr_match_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		frame_seen && frame_addr == slave_q |=> addr_match)
		else $error("own address not matched");

	silence_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		frame_seen || timeout_q == 6'h00 |=> !outputs_zero)
		else $error("outputs stay zeroed despite traffic");

	alert_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!autotune && pressure[15] |=> alert)
		else $error("negative pressure raised no alert");

endmodule

// ---- pscfg_pkg.sv ----
// Constants, register map and codes of the pressure sensor config bank
package pscfg_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned SEC_PER_MIN = 60;
	// Cycles per minute of link silence; above 4096, so the top exposes it
	localparam int unsigned CYC_PER_MIN = CLK_HZ * SEC_PER_MIN;

	// ==========================================================
	// Modbus function and exception codes
	localparam logic [7:0] FN_RD_HOLD = 8'h03;
	localparam logic [7:0] FN_RD_INP  = 8'h04;
	localparam logic [7:0] FN_WR_ONE  = 8'h06;
	localparam logic [7:0] EX_FUNC    = 8'h01;
	localparam logic [7:0] EX_ADDR    = 8'h02;
	localparam logic [7:0] EX_VALUE   = 8'h03;

	// ==========================================================
	// Holding register numbers
	localparam logic [15:0] HR_SLAVE    = 16'h0001;
	localparam logic [15:0] HR_RATE     = 16'h0002;
	localparam logic [15:0] HR_PARITY   = 16'h0003;
	localparam logic [15:0] HR_MODEL    = 16'h0004;
	localparam logic [15:0] HR_HW_REV   = 16'h0005;
	localparam logic [15:0] HR_FW_REV   = 16'h0006;
	localparam logic [15:0] HR_RSVD     = 16'h0007;
	localparam logic [15:0] HR_TIMEOUT  = 16'h0008;
	localparam logic [15:0] HR_TERM     = 16'h0009;
	localparam logic [15:0] HR_RESTORE  = 16'h000a;
	localparam logic [15:0] HR_LOW_ALRT = 16'h000b;
	localparam logic [15:0] HR_HIGH_ALRT = 16'h000c;
	// Reserved input registers
	localparam logic [15:0] IR_RSVD_LO  = 16'h000c;
	localparam logic [15:0] IR_RSVD_HI  = 16'h0014;

	// ==========================================================
	// Factory defaults and legal limits
	localparam logic [15:0] RST_SLAVE   = 16'h0001;
	localparam logic [15:0] RST_RATE    = 16'h0002;
	localparam logic [15:0] RST_PARITY  = 16'h0001;
	localparam logic [15:0] RST_TIMEOUT = 16'h0000;
	localparam logic [15:0] RST_TERM    = 16'h0000;
	localparam logic [15:0] RST_RESTORE = 16'h0000;
	localparam logic [15:0] RST_LOW     = 16'h0000;
	localparam logic [15:0] SLAVE_MIN   = 16'h0001;
	localparam logic [15:0] SLAVE_MAX   = 16'h00f7;
	localparam logic [15:0] RATE_MAX    = 16'h0006;
	localparam logic [15:0] PARITY_MAX  = 16'h0002;
	localparam logic [15:0] TIMEOUT_MAX = 16'h003c;
	localparam logic [15:0] FLAG_MAX    = 16'h0001;
	localparam logic [15:0] ALERT_GAP   = 16'h0032;

	// ==========================================================
	// Parity modes
	typedef enum logic [1:0] {
		PSCFG_PAR_NONE = 2'b00,
		PSCFG_PAR_EVEN = 2'b01,
		PSCFG_PAR_ODD  = 2'b10
	} pscfg_parity_t;

	// ==========================================================
	// Bit time in clock cycles for each rate code, rounded down
	function automatic logic [15:0] pscfg_bit_cycles(input logic [2:0] code);
		logic [15:0] c;
		c = 16'(CLK_HZ / 19200);
		case (code)
			3'h0: c = 16'(CLK_HZ / 4800);
			3'h1: c = 16'(CLK_HZ / 9600);
			3'h2: c = 16'(CLK_HZ / 19200);
			3'h3: c = 16'(CLK_HZ / 38400);
			3'h4: c = 16'(CLK_HZ / 57600);
			3'h5: c = 16'(CLK_HZ / 115200);
			3'h6: c = 16'(CLK_HZ / 230400);
			default: c = 16'(CLK_HZ / 19200);
		endcase
		return c;
	endfunction

endpackage

// ---- pscfg_bit_tick.sv ----
// Bit-rate enable pulse divider for the serial link
`timescale 1ns/1ps

module pscfg_bit_tick (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Rate code
	input  wire logic [2:0] rate_code,
	// Enable pulse, one cycle per bit time
	output logic            bit_tick
);
	import pscfg_pkg::*;

	logic [15:0] cnt_q;
	logic [15:0] span;
	logic [2:0]  code_q;

	assign span = pscfg_bit_cycles(rate_code);

	// ==========================================================
	// Divider; a rate change restarts the bit time
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt_q    <= 16'h0000;
			code_q   <= 3'h2;
			bit_tick <= 1'b0;
		end else if (code_q != rate_code) begin
			code_q   <= rate_code;
			cnt_q    <= 16'h0000;
			bit_tick <= 1'b0;
		end else if (cnt_q == span - 16'h0001) begin
			cnt_q    <= 16'h0000;
			bit_tick <= 1'b1;
		end else begin
			cnt_q    <= cnt_q + 16'h0001;
			bit_tick <= 1'b0;
		end
	end

	// A counter past its span would stretch the bit time until the 16-bit counter wraps
	tick_span_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		code_q == rate_code |-> cnt_q < span)
		else $error("bit counter past its span");

endmodule

// ---- pscfg_master.sv ----
// Modbus master model driving decoded register requests
`timescale 1ns/1ps

module pscfg_master (
	// Clock
	input  wire logic        clk_sys,
	// Request
	output logic             req_valid,
	output logic [7:0]       req_func,
	output logic [15:0]      req_addr,
	output logic [15:0]      req_wdata,
	// Answer
	input  wire logic        resp_valid,
	input  wire logic        resp_exc,
	input  wire logic [7:0]  resp_exc_code,
	input  wire logic [15:0] resp_data
);
	// ==========================================================
	// Last answer seen
	logic        got_v;
	logic        got_x;
	logic [7:0]  got_c;
	logic [15:0] got_d;

	initial begin
		req_valid = 1'b0;
		req_func  = 8'h00;
		req_addr  = 16'h0000;
		req_wdata = 16'h0000;
	end

	// ==========================================================
	// One request, held until the answering edge
	task automatic xfer(input logic [7:0] fn, input logic [15:0] a,
		input logic [15:0] d, input int gap);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_func  <= fn; // Input words only via read-input
		req_addr  <= a;
		req_wdata <= d;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		// Idle fields toggle so a stale value never passes as valid
		req_func  <= ~fn;
		req_addr  <= ~a;
		req_wdata <= ~d;
		#1;
		got_v = resp_valid;
		got_x = resp_exc;
		got_c = resp_exc_code;
		got_d = resp_data;
	endtask
endmodule

// ---- pscfg_regs_bench.sv ----
// Self-checking bench of the pressure sensor config bank
`timescale 1ns/1ps

module pscfg_regs_bench;
	import pscfg_pkg::*;
	// ==========================================================
	// Setup
	localparam logic [15:0] MID  = 16'h0c3d; // Value is arbitrary
	localparam logic [15:0] HWR  = 16'h0203; // Value is arbitrary
	localparam logic [15:0] FWR  = 16'h0304; // Value is arbitrary
	localparam int          MINC = 20;
	logic          clk_sys = 1'b0;
	logic          rst_n = 1'b0;
	logic          req_valid;
	logic [7:0]    req_func;
	logic [15:0]   req_addr;
	logic [15:0]   req_wdata;
	logic          resp_valid;
	logic          resp_exc;
	logic [7:0]    resp_exc_code;
	logic [15:0]   resp_data;
	logic          frame_seen = 1'b0;
	logic [7:0]    frame_addr = 8'h00;
	logic          addr_match;
	logic          bit_tick;
	pscfg_parity_t parity_mode;
	logic          term_en;
	logic [15:0]   pressure = 16'h0000;
	logic [15:0]   setpoint = 16'h0190;
	logic          autotune = 1'b0;
	logic          alert;
	logic          outputs_zero;
	int            n_errors = 0;
	int            cmp_count = 0;
	int            rg [1:12];
	int            sp = 400;
	int            rates [7] = '{4800, 9600, 19200, 38400, 57600, 115200,
		230400};
	int            ba [16] = '{1, 1, 1, 3, 3, 8, 9, 9, 10, 11, 11, 11, 12,
		12, 12, 12};
	int            bd [16] = '{0, 248, 247, 3, 2, 61, 2, 1, 2, 951, 401,
		400, 49, 1001, 399, 400};

	always #50 clk_sys = ~clk_sys;

	pscfg_regs #(.MODEL_ID(MID), .HW_REV(HWR), .FW_REV(FWR),
		.MIN_CYCLES(MINC)) dut (.*);
	pscfg_master m_model (.*);

	// ==========================================================
	// Compare and verdict
	task automatic chk_word(input logic [15:0] g, input logic [15:0] e,
		input string what);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask

	task automatic chk_bit(input logic g, input logic e, input string what);
		chk_word({15'h0000, g}, {15'h0000, e}, what);
	endtask

	task automatic close_out;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#(100 * 90000);
		n_errors++;
		close_out();
	end

	// ==========================================================
	// Reference model
	task automatic defaults;
		rg = '{1, 2, 1, MID, HWR, FWR, 0, 0, 0, 0, 0, 1000};
	endtask

	function automatic bit legal(int a, int d);
		case (a)
			1: return d >= 1 && d <= 247;
			2: return d <= 6;
			3: return d <= 2;
			8: return d <= 60;
			9, 10: return d <= 1;
			11: return d <= sp && d <= 950;
			12: return d >= sp && d >= 50 && d <= 1000;
			default: return 0;
		endcase
	endfunction

	task automatic txn(input int fn, input int a, input int d);
		int c;
		int e;
		int p;
		c = 0;
		e = 0;
		if (fn == 3) begin
			if (a >= 1 && a <= 12) e = rg[a];
			else c = 2;
		end else if (fn == 4) begin
			if (a < 12 || a > 20) c = 2;
		end else if (fn == 6) begin
			if (a < 1 || a > 12 || (a >= 4 && a <= 7)) c = 2;
			else if (!legal(a, d)) c = 3;
			else begin
				e = d;
				rg[a] = d;
				if (a == 10 && d == 1) defaults();
			end
		end else c = 1;
		m_model.xfer(8'(fn), 16'(a), 16'(d), $urandom % 3);
		chk_bit(m_model.got_v, 1'b1, "answer");
		chk_bit(m_model.got_x, c != 0, "refusal");
		chk_word(16'(m_model.got_c), 16'(c), "code");
		chk_word(m_model.got_d, 16'(e), "data");
		// Two edges: a restore reloads one cycle after its answer
		repeat (2) @(posedge clk_sys);
		#1;
		p = int'($signed(pressure));
		p = (p < rg[11] || p > rg[12]) ? 1 : 0;
		chk_word(16'(parity_mode), 16'(rg[3]), "parity");
		chk_bit(term_en, rg[9] == 1, "termination");
		chk_bit(alert, !autotune && p == 1, "alert");
	endtask

	task automatic frame(input int a, input logic e);
		@(posedge clk_sys);
		frame_seen <= 1'b1;
		frame_addr <= 8'(a);
		@(posedge clk_sys);
		frame_seen <= 1'b0;
		#1;
		chk_bit(addr_match, e, "address match");
	endtask

	task automatic tick_span(input int code);
		int n;
		n = 0;
		while (bit_tick !== 1'b1 && n < 3000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (bit_tick !== 1'b1 && n < 3000);
		chk_word(16'(n), 16'(CLK_HZ / rates[code]), "bit time");
	endtask

	// ==========================================================
	// Tests
	initial begin
		void'($urandom(63));
		defaults();
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int a = 1; a <= 12; a++) txn(3, a, 0);
		for (int a = 11; a <= 21; a++) txn(4, a, 0);
		txn(3, 0, 0);
		txn(3, 13, 0);
		txn(5, 1, 0);
		for (int a = 4; a <= 7; a++) txn(6, a, 255);
		for (int a = 4; a <= 7; a++) txn(3, a, 0);
		for (int c = 6; c >= 0; c--) begin
			txn(6, 2, c);
			tick_span(c);
		end
		txn(6, 2, 7);
		for (int i = 0; i < 16; i++) txn(6, ba[i], bd[i]);
		txn(6, 10, 1);
		for (int a = 1; a <= 12; a++) txn(3, a, 0);
		txn(6, 1, 90);
		frame(90, 1'b1);
		frame(91, 1'b0);
		txn(6, 8, 1);
		frame(90, 1'b1);
		repeat (MINC - 5) @(posedge clk_sys);
		#1;
		chk_bit(outputs_zero, 1'b0, "early silence");
		repeat (10) @(posedge clk_sys);
		#1;
		chk_bit(outputs_zero, 1'b1, "silence");
		frame(5, 1'b0);
		@(posedge clk_sys);
		#1;
		chk_bit(outputs_zero, 1'b0, "traffic clears");
		txn(6, 8, 0);
		repeat (3 * MINC) @(posedge clk_sys);
		#1;
		chk_bit(outputs_zero, 1'b0, "disabled");
		for (int i = 0; i < 80; i++) begin
			@(posedge clk_sys);
			sp = $urandom % 1000;
			setpoint <= 16'(sp);
			pressure <= 16'(int'($urandom % 1200) - 100);
			autotune <= ($urandom % 4) == 0;
			txn(i % 3 ? 6 : 3, 1 + $urandom % 12,
				$urandom % 1100);
		end
		close_out();
	end
endmodule
